/* logic/edsp_core.v */
// external bus sequencer with stretch control and dual data pointer
`timescale 1ns/1ps
`include "edsp_map.vh"
module edsp_core (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // special-function register port from the core
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  output reg [7:0] sfr_rdata,
  // pointer operations from the core
  input wire ptr_inc,
  input wire sel_inc,
  input wire ptr_load,
  input wire [15:0] ptr_load_value,
  output wire [15:0] data_pointer,
  // bus requests from the core
  input wire fetch_req,
  input wire [15:0] fetch_addr,
  input wire move_req,
  input wire move_write,
  input wire move_use_ptr,
  input wire [15:0] move_addr,
  input wire [7:0] move_wdata,
  output wire busy,
  output reg done,
  output reg [7:0] rdata,
  // external bus pins
  input wire [7:0] low_addr_data_port_in,
  output reg [7:0] low_addr_data_port_out,
  output reg low_addr_data_port_oe_n,
  output reg [7:0] high_addr_port,
  output reg addr_latch,
  output reg fetch_strobe_n,
  output reg read_strobe_n,
  output reg write_strobe_n
);

  // one-hot sequencer states
  localparam ST_IDLE = 4'b0001;
  localparam ST_ADDR = 4'b0010;
  localparam ST_STROBE = 4'b0100;
  localparam ST_TAIL = 4'b1000;

  // software-visible registers
  reg [7:0] primary_pointer_low;
  reg [7:0] primary_pointer_high;
  reg [7:0] secondary_pointer_low;
  reg [7:0] secondary_pointer_high;
  reg pointer_select;
  reg [7:0] timing_control;

  // sequencer state; count and tail_len are both clock counts
  reg [3:0] state;
  reg [7:0] count;
  reg [7:0] tail_len;
  reg is_fetch;
  reg is_write;

  // data pin synchroniser stages
  reg [7:0] pin_meta;
  reg [7:0] pin_sync;

  // decoded views and pointer arithmetic
  wire [2:0] stretch;
  wire [15:0] active_ptr;
  wire [15:0] ptr_plus;
  wire [5:0] wr_hit;
  wire ptr_op;
  wire [15:0] ptr_next;

  assign stretch = timing_control[`EDSP_STRETCH_MSB:`EDSP_STRETCH_LSB];
  // only the selected pointer is presented, loaded or incremented; byte writes reach either one
  assign active_ptr = pointer_select ? {secondary_pointer_high, secondary_pointer_low}
                                     : {primary_pointer_high, primary_pointer_low};
  assign ptr_plus = active_ptr + 16'h0001;
  assign data_pointer = active_ptr;
  assign busy = (state != ST_IDLE);

  // strobe width in clocks for a given stretch
  function [7:0] strobe_clocks;
    input [2:0] s;
    begin
      if (s == 3'h0) begin
        strobe_clocks = `EDSP_ZERO_STRETCH_STROBE;
      end else begin
        strobe_clocks = `EDSP_STROBE_PER_STEP * {5'h00, s};
      end
    end
  endfunction

  // total clocks of a data move: (2 + stretch) machine cycles
  function [7:0] move_clocks;
    input [2:0] s;
    begin
      move_clocks = {4'h0, `EDSP_CLOCKS_PER_CYCLE} *
                    ({4'h0, `EDSP_BASE_DATA_CYCLES} + {5'h00, s});
    end
  endfunction

  // read data pins pass two flops before use
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pin_meta <= 8'h00;
      pin_sync <= 8'h00;
    end else begin
      pin_meta <= low_addr_data_port_in;
      pin_sync <= pin_meta;
    end
  end

  // one-hot register decode shared by the write processes
  function [5:0] reg_hit;
    input [7:0] a;
    begin
      reg_hit = 6'h00;
      case (a)
        `EDSP_ADDR_PTR0_LOW: reg_hit = 6'h01;
        `EDSP_ADDR_PTR0_HIGH: reg_hit = 6'h02;
        `EDSP_ADDR_PTR1_LOW: reg_hit = 6'h04;
        `EDSP_ADDR_PTR1_HIGH: reg_hit = 6'h08;
        `EDSP_ADDR_PTR_SEL: reg_hit = 6'h10;
        `EDSP_ADDR_TIMING: reg_hit = 6'h20;
        default: reg_hit = 6'h00;
      endcase
    end
  endfunction

  // a register write outranks the toggle pulse, which outranks load and increment
  assign wr_hit = sfr_wr ? reg_hit(sfr_addr) : 6'h00;
  assign ptr_op = !sfr_wr && !sel_inc && (ptr_load || ptr_inc);
  // the increment wraps at 16 bits
  assign ptr_next = ptr_load ? ptr_load_value : ptr_plus;

  // timing control: software may retune at any moment; the sequencer latches per move
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      timing_control <= `EDSP_TIMING_RESET;
    end else if (wr_hit[5]) begin
      timing_control <= sfr_wdata;
    end
  end

  // select bit: only bit 0 is stored
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pointer_select <= `EDSP_SEL_RESET;
    end else if (wr_hit[4]) begin
      pointer_select <= sfr_wdata[0];
    end else if (!sfr_wr && sel_inc) begin
      pointer_select <= ~pointer_select;
    end
  end

  // primary pointer bytes; load and increment only while it is selected
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      primary_pointer_low <= `EDSP_PTR_RESET;
      primary_pointer_high <= `EDSP_PTR_RESET;
    end else if (ptr_op && !pointer_select) begin
      // ptr_op excludes sfr_wr, so a byte write never meets a pointer operation
      {primary_pointer_high, primary_pointer_low} <= ptr_next;
    end else begin
      if (wr_hit[0]) begin
        primary_pointer_low <= sfr_wdata;
      end
      if (wr_hit[1]) begin
        primary_pointer_high <= sfr_wdata;
      end
    end
  end

  // secondary pointer bytes; load and increment only while it is selected
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      secondary_pointer_low <= `EDSP_PTR_RESET;
      secondary_pointer_high <= `EDSP_PTR_RESET;
    end else if (ptr_op && pointer_select) begin
      // ptr_op excludes sfr_wr, so a byte write never meets a pointer operation
      {secondary_pointer_high, secondary_pointer_low} <= ptr_next;
    end else begin
      if (wr_hit[2]) begin
        secondary_pointer_low <= sfr_wdata;
      end
      if (wr_hit[3]) begin
        secondary_pointer_high <= sfr_wdata;
      end
    end
  end

  // read mux; unmapped addresses read zero
  // read data is combinational and zero whenever sfr_rd is low
  always @* begin
    sfr_rdata = 8'h00;
    if (sfr_rd) begin
      case (sfr_addr)
        `EDSP_ADDR_PTR0_LOW: sfr_rdata = primary_pointer_low;
        `EDSP_ADDR_PTR0_HIGH: sfr_rdata = primary_pointer_high;
        `EDSP_ADDR_PTR1_LOW: sfr_rdata = secondary_pointer_low;
        `EDSP_ADDR_PTR1_HIGH: sfr_rdata = secondary_pointer_high;
        `EDSP_ADDR_PTR_SEL: sfr_rdata = {7'h00, pointer_select};
        `EDSP_ADDR_TIMING: sfr_rdata = timing_control;
        default: sfr_rdata = 8'h00;
      endcase
    end
  end

  // bus sequencer: one address clock, strobe phase, tail to fill the cycles
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      count <= 8'h00;
      tail_len <= 8'h00;
      is_fetch <= 1'b0;
      is_write <= 1'b0;
      done <= 1'b0;
      rdata <= 8'h00;
      low_addr_data_port_out <= 8'h00;
      low_addr_data_port_oe_n <= 1'b1;
      high_addr_port <= 8'h00;
      addr_latch <= 1'b0;
      fetch_strobe_n <= 1'b1;
      read_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
    end else begin
      done <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (fetch_req) begin
            // program fetch: fixed 4-clock cycle, stretch ignored
            is_fetch <= 1'b1;
            is_write <= 1'b0;
            high_addr_port <= fetch_addr[15:8];
            low_addr_data_port_out <= fetch_addr[7:0];
            low_addr_data_port_oe_n <= 1'b0;
            addr_latch <= 1'b1;
            // two strobe clocks and one tail clock complete the fixed cycle
            count <= `EDSP_FETCH_STROBE;
            tail_len <= `EDSP_FETCH_TAIL;
            state <= ST_ADDR;
          end else if (move_req) begin
            // stretch captured here so a later write cannot alter this move
            is_fetch <= 1'b0;
            is_write <= move_write;
            high_addr_port <= move_use_ptr ? active_ptr[15:8] : move_addr[15:8];
            low_addr_data_port_out <= move_use_ptr ? active_ptr[7:0] : move_addr[7:0];
            low_addr_data_port_oe_n <= 1'b0;
            addr_latch <= 1'b1;
            count <= strobe_clocks(stretch);
            tail_len <= move_clocks(stretch) - strobe_clocks(stretch) - 8'h01;
            state <= ST_ADDR;
          end
        end

        // address phase over: turn the port for reads, drive write data
        ST_ADDR: begin
          addr_latch <= 1'b0;
          if (is_write) begin
            low_addr_data_port_out <= move_wdata;
          end else begin
            low_addr_data_port_oe_n <= 1'b1;
          end
          fetch_strobe_n <= ~is_fetch;
          read_strobe_n <= is_fetch | is_write;
          write_strobe_n <= ~is_write;
          state <= ST_STROBE;
        end

        // strobe low for the width captured at the request
        ST_STROBE: begin
          if (count == 8'h01) begin
            // end of strobe; read data is taken two tail clocks later
            fetch_strobe_n <= 1'b1;
            read_strobe_n <= 1'b1;
            write_strobe_n <= 1'b1;
            count <= tail_len;
            state <= ST_TAIL;
          end else begin
            count <= count - 8'h01;
          end
        end

        // tail: strobes released, port turned around
        ST_TAIL: begin
          // tail stands >=1 clock; fetch total is 4 clocks
          low_addr_data_port_oe_n <= 1'b1;
          // two-flop latency: the byte seen in the last strobe clock lands here
          if (!is_write && !is_fetch && count == tail_len - 8'h01) begin
            rdata <= pin_sync;
          end
          if (count <= 8'h01) begin
            done <= 1'b1;
            state <= ST_IDLE;
          end else begin
            count <= count - 8'h01;
          end
        end

        // stray codes fall back to idle
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule

/* logic/edsp_map.vh */
// constants for the external data access, stretch and dual pointer block
// Operation
// - all program fetches go to external memory
// - low address/data multiplexed, high address separate
// - machine cycle is 4 clocks, fetches unstretched
// - software sets a 3-bit stretch 0..7
// - data move takes two plus stretch cycles
// - stretch resets to 1
// - strobe 2 clocks at 0, else 4 per step
// - stretch touches data cycles only
// - stretch in bits 2..0 at 8Eh
// - primary pointer at 82h and 83h
// - secondary pointer at 84h and 85h
// - bit 0 at 86h selects pointer
// - select bits 7..1 inert, read zero
// - toggling select bit switches active pointer
// - pointer operations use only selected pointer
// - select bit resets to zero
`ifndef EDSP_MAP_VH
`define EDSP_MAP_VH
`define EDSP_ADDR_PTR0_LOW 8'h82
`define EDSP_ADDR_PTR0_HIGH 8'h83
`define EDSP_ADDR_PTR1_LOW 8'h84
`define EDSP_ADDR_PTR1_HIGH 8'h85
`define EDSP_ADDR_PTR_SEL 8'h86
`define EDSP_ADDR_TIMING 8'h8E
`define EDSP_STRETCH_LSB 0
`define EDSP_STRETCH_MSB 2
`define EDSP_TIMING_RESET 8'h01
`define EDSP_SEL_RESET 1'h0
`define EDSP_CLOCKS_PER_CYCLE 4'h4
`define EDSP_ZERO_STRETCH_STROBE 8'h02
`define EDSP_STROBE_PER_STEP 8'h04
`define EDSP_BASE_DATA_CYCLES 4'h2
`define EDSP_FETCH_STROBE 8'h02
`define EDSP_FETCH_TAIL 8'h01
`define EDSP_PTR_RESET 8'h00
`endif

/* verification/edsp_core_chk.sv */
// assertions on the bus sequencer and register port
`timescale 1ns/1ps
module edsp_core_chk (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // watched ports
  input wire sfr_rd,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_rdata,
  input wire fetch_req,
  input wire move_req,
  input wire busy,
  input wire done,
  input wire low_addr_data_port_oe_n,
  input wire addr_latch,
  input wire fetch_strobe_n,
  input wire read_strobe_n,
  input wire write_strobe_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // register port and timing
  a_sel_upper_zero: assert property (sfr_rd && sfr_addr == 8'h86 |-> sfr_rdata[7:1] == 7'h00)
    else $error("select upper bits set");
  a_fetch_strobe_two: assert property ($fell(fetch_strobe_n) |=> !fetch_strobe_n ##1 fetch_strobe_n)
    else $error("fetch strobe width");
  a_fetch_four_clocks: assert property (fetch_req && !busy |-> ##5 done)
    else $error("fetch length");
  a_move_cycle_span: assert property (move_req && !fetch_req && !busy |-> ##[9:37] done)
    else $error("move length");
  a_fetch_no_data: assert property (!fetch_strobe_n |-> read_strobe_n && write_strobe_n)
    else $error("data strobe during fetch");
  a_latch_then_read: assert property ($fell(read_strobe_n) |-> $past(addr_latch))
    else $error("read without address phase");
  a_read_strobe_min: assert property ($fell(read_strobe_n) |=> !read_strobe_n)
    else $error("read strobe short");
  a_read_released: assert property (!read_strobe_n |-> low_addr_data_port_oe_n)
    else $error("port driven during read");
  a_write_driven: assert property (!write_strobe_n |-> !low_addr_data_port_oe_n)
    else $error("port not driven during write");
endmodule
bind edsp_core edsp_core_chk u_chk (.*);

/* verification/edsp_ram.sv */
// behavioural external ram on the multiplexed bus
`timescale 1ns/1ps
module edsp_ram (
  // bus side
  input wire ref_clk,
  input wire [7:0] bus,
  input wire [7:0] high_addr_port,
  input wire addr_latch,
  input wire read_strobe_n,
  input wire write_strobe_n,
  // data toward the pins
  output wire [7:0] q
);
  reg [7:0] mem [0:65535];
  reg [15:0] a = 16'h0000;
  reg [7:0] last = 8'h00;
  // released lines toggle so a stale byte is never read as good
  always @(posedge ref_clk) begin
    if (addr_latch) a <= {high_addr_port, bus};
    if (!write_strobe_n) mem[a] <= bus;
    last <= read_strobe_n ? ~last : mem[a];
  end
  assign q = read_strobe_n ? last : mem[a];
endmodule

/* verification/ext_data_access_stretch_dual_ptr_test.sv */
// testbench for the bus sequencer with stretch and dual pointer
`timescale 1ns/1ps
module ext_data_access_stretch_dual_ptr_test;
  reg ref_clk = 0, rst = 1, sfr_wr = 0, sfr_rd = 0, ptr_inc = 0, sel_inc = 0, ptr_load = 0;
  reg fetch_req = 0, move_req = 0, move_write = 0, move_use_ptr = 0;
  reg [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, move_wdata = 8'h00, d;
  reg [15:0] ptr_load_value = 16'h0000, fetch_addr = 16'h0000, move_addr = 16'h0000, p0, p1, a;
  wire [7:0] sfr_rdata, rdata, low_addr_data_port_out, high_addr_port, ram_q;
  wire [15:0] data_pointer;
  wire busy, done, low_addr_data_port_oe_n, addr_latch, fetch_strobe_n, read_strobe_n;
  wire write_strobe_n;
  wire [7:0] low_addr_data_port_in = low_addr_data_port_oe_n ? ram_q : low_addr_data_port_out;
  int num_errors = 0, check_count = 0, n, w, s;
  edsp_core dut (.*);
  edsp_ram ram (.*, .bus(low_addr_data_port_in), .q(ram_q));
  // clock and watchdog
  initial forever #2.5 ref_clk = ~ref_clk;
  initial begin
    #50000;
    num_errors++;
    final_report;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input [7:0] ad, input [7:0] dt);
    @(negedge ref_clk); sfr_wr = 1; sfr_addr = ad; sfr_wdata = dt;
    @(negedge ref_clk); sfr_wr = 0;
  endtask
  task rd(input [7:0] ad);
    @(negedge ref_clk); sfr_rd = 1; sfr_addr = ad; #1;
  endtask
  task pulse(input [2:0] k, input [15:0] v);
    @(negedge ref_clk); {ptr_inc, sel_inc, ptr_load} = k; ptr_load_value = v;
    @(negedge ref_clk); {ptr_inc, sel_inc, ptr_load} = 3'h0;
  endtask
  // one transfer; n = clocks to done, w = clocks any strobe low
  task bus(input mv, input wr_, input up, input [15:0] ad, input [7:0] dt);
    @(negedge ref_clk); fetch_req = !mv; move_req = mv; move_write = wr_; move_use_ptr = up;
    move_addr = ad; fetch_addr = ad; move_wdata = dt;
    @(negedge ref_clk); fetch_req = 0; move_req = 0; n = 0; w = 0;
    while (done !== 1'b1 && n < 60) begin
      w += ((read_strobe_n & write_strobe_n & fetch_strobe_n) === 1'b0);
      @(negedge ref_clk); n++;
    end
  endtask
  task final_report;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // main sequence
  initial begin
    void'($urandom(32'h8669));
    repeat (4) @(negedge ref_clk);
    rst = 0;
    rd(8'h86); chk(sfr_rdata, 8'h00);
    rd(8'h8E); chk(sfr_rdata, 8'h01);
    bus(1, 0, 0, 16'h0000, 8'h00); chk(n, 12);
    $display("reset test done");
    p0 = $urandom; p1 = $urandom;
    wr(8'h82, p0[7:0]); wr(8'h83, p0[15:8]); wr(8'h84, p1[7:0]); wr(8'h85, p1[15:8]);
    rd(8'h83); chk(sfr_rdata, p0[15:8]);
    rd(8'h84); chk(sfr_rdata, p1[7:0]);
    chk(data_pointer, p0);
    wr(8'h86, 8'hFF); rd(8'h86); chk(sfr_rdata, 8'h01);
    chk(data_pointer, p1);
    a = p1 + 16'h0001;
    pulse(3'h4, 0); chk(data_pointer, a);
    pulse(3'h2, 0); chk(data_pointer, p0);
    pulse(3'h1, 16'hC3A5); rd(8'h83); chk(sfr_rdata, 8'hC3);
    rd(8'h85); chk(sfr_rdata, a[15:8]);
    bus(1, 1, 1, 16'h0000, 8'h5A); chk(ram.mem[16'hC3A5], 8'h5A);
    $display("pointer test done");
    for (s = 0; s < 8; s++) begin
      a = $urandom; d = $urandom; wr(8'h8E, s[7:0]);
      rd(8'h8E); chk(sfr_rdata, s[7:0]);
      bus(1, 1, 0, a, d); chk(n, 4 * (2 + s));
      chk(w, s ? 4 * s : 2);
      bus(1, 0, 0, a, 8'h00); chk(rdata, d);
      bus(0, 0, 0, a, 8'h00); chk(n, 4);
      chk(w, 2);
    end
    $display("stretch test done");
    // stretch rewritten mid-move by software
    fork
      bus(1, 0, 0, a, 8'h00);
      begin repeat (6) @(negedge ref_clk); wr(8'h8E, 8'h00); end
    join
    chk(n, 36);
    bus(1, 0, 0, a, 8'h00); chk(n, 8);
    $display("change test done");
    final_report;
  end
endmodule
